// *** logic/mdv_cfg.svh ***
`ifndef MDV_CFG_SVH
`define MDV_CFG_SVH

`define MDV_W 32
`define MDV_HALF 16
`define MDV_BYTE 8
`define MDV_CNT_W 6
`define MDV_OP_W 4
`define MDV_PROD_W 50

// Early-in skip counts for 8/16/24-bit dividends
`define MDV_SKIP_8 6'h17
`define MDV_SKIP_16 6'h0F
`define MDV_SKIP_24 6'h07
`define MDV_SKIP_32 6'h00

// Divide latency and repeat rate, in clocks
`define MDV_DIV_LAT_8 6'h0C
`define MDV_DIV_LAT_16 6'h13
`define MDV_DIV_LAT_24 6'h1A
`define MDV_DIV_LAT_32 6'h21
`define MDV_DIV_REP_8 6'h0B
`define MDV_DIV_REP_16 6'h12
`define MDV_DIV_REP_24 6'h19
`define MDV_DIV_REP_32 6'h20

// Multiply result to general register: extra stage count
`define MDV_GPR_STAGES 1

`endif

// *** logic/mdv_early_in.sv ***
`timescale 1ns/1ps
`include "mdv_cfg.svh"

// Finds how far the dividend is sign or zero extended
module mdv_early_in (
  input wire logic [`MDV_W-1:0] dividend,
  input wire logic is_signed,
  output mdv_pkg::mdv_div_plan_s plan
);
  import mdv_pkg::*;

  localparam int CW = `MDV_CNT_W;

  logic [2:0] fits;

  genvar k;
  generate
    for (k = 1; k <= 3; k++) begin : g_width
      localparam int unsigned WB = `MDV_BYTE * k;
      // Signed: bits above the sign bit all match it
      assign fits[k-1] = is_signed ?
        (&dividend[`MDV_W-1:WB-1]) | ~(|dividend[`MDV_W-1:WB-1]) :
        ~(|dividend[`MDV_W-1:WB]);
    end
  endgenerate

  always_comb begin
    if (fits[0]) begin
      plan = '{`MDV_SKIP_8, CW'(`MDV_W - `MDV_SKIP_8), `MDV_DIV_REP_8};
    end else if (fits[1]) begin
      plan = '{`MDV_SKIP_16, CW'(`MDV_W - `MDV_SKIP_16), `MDV_DIV_REP_16};
    end else if (fits[2]) begin
      plan = '{`MDV_SKIP_24, CW'(`MDV_W - `MDV_SKIP_24), `MDV_DIV_REP_24};
    end else begin
      plan = '{`MDV_SKIP_32, CW'(`MDV_W - `MDV_SKIP_32), `MDV_DIV_REP_32};
    end
  end

endmodule

// *** logic/mdv_muldiv_unit.sv ***
// What this block does
// - Own pipeline, advances regardless of integer stalls
// - 32x16 multiplier; operand B sets pass count
// - 32x16 every cycle, 32x32 every other
// - Top/bottom result words; accumulate or subtract
// - Divide one quotient bit per clock
// - Skip 23/15/7 iterations by dividend width
// - Busy for all divide cycles but the last; pipeline must wait
// - Result-pair multiplies: latency/repeat 1/1, 2/2
// - Register multiply: latency 2 or 3
// - Divide latency 12/19/26/33, repeat 11/18/25/32
// - Signed and unsigned accumulate and subtract forms
`timescale 1ns/1ps
`include "mdv_cfg.svh"

module mdv_muldiv_unit (
  input wire logic ref_clk,
  input wire logic rst_n,
  input mdv_pkg::mdv_issue_s issue,
  output logic busy,
  output logic [`MDV_W-1:0] result_top_word,
  output logic [`MDV_W-1:0] result_bottom_word,
  output mdv_pkg::mdv_gpr_s gpr_result
);
  import mdv_pkg::*;

  typedef struct packed {
    mdv_state_e st;
    logic busy;
    logic [`MDV_W-1:0] top;
    logic [`MDV_W-1:0] bot;
    mdv_op_e op;
    logic signed [`MDV_W:0] mcand;
    logic signed [`MDV_HALF:0] b_high;
    logic [2*`MDV_W-1:0] part;
    logic [`MDV_W-1:0] rem;
    logic [`MDV_W-1:0] quo;
    logic [`MDV_W-1:0] dvs;
    logic neg_quo;
    logic neg_rem;
    logic [`MDV_CNT_W-1:0] iter;
    logic [`MDV_CNT_W-1:0] cyc;
    mdv_gpr_s stage;
    mdv_gpr_s gpr;
  } mdv_unit_s;

  mdv_unit_s s_q;
  mdv_unit_s s_d;

  logic accept;
  logic sgn;
  logic fits16;
  logic signed [`MDV_W:0] a_ext;
  logic signed [`MDV_HALF:0] b_low;
  logic signed [`MDV_HALF:0] b_high_in;
  logic signed [`MDV_W:0] mul_a;
  logic signed [`MDV_HALF:0] mul_b;
  logic signed [`MDV_PROD_W-1:0] prod;
  logic [2*`MDV_W-1:0] prod64;
  logic [2*`MDV_W-1:0] full;
  logic [2*`MDV_W-1:0] base;
  logic [`MDV_W:0] div_rt;
  logic [`MDV_W-1:0] rem_n;
  logic [`MDV_W-1:0] quo_n;
  logic [`MDV_W-1:0] a_mag;
  mdv_div_plan_s plan;

  function automatic logic op_signed(input mdv_op_e op);
    case (op)
      op_product_signed, op_product_accumulate_signed,
      op_product_subtract_signed, op_product_to_register,
      op_quotient_signed: op_signed = 1'h1;
      default: op_signed = 1'h0;
    endcase
  endfunction

  function automatic logic op_divide(input mdv_op_e op);
    op_divide = (op == op_quotient_signed) || (op == op_quotient_unsigned);
  endfunction

  // A new op is taken whenever the strobe meets a not-busy unit
  assign accept = issue.valid && !s_q.busy;
  assign sgn = op_signed(issue.op);

  // Operand B, read signed or unsigned by the op, decides one pass or two
  assign fits16 = sgn ?
    (&issue.source_b_operand[`MDV_W-1:`MDV_HALF-1]) |
    ~(|issue.source_b_operand[`MDV_W-1:`MDV_HALF-1]) :
    ~(|issue.source_b_operand[`MDV_W-1:`MDV_HALF]);
  assign a_ext = {sgn & issue.source_a_operand[`MDV_W-1],
                  issue.source_a_operand};
  // Two-pass low half is unsigned; one-pass half carries the sign
  assign b_low = {fits16 & sgn & issue.source_b_operand[`MDV_HALF-1],
                  issue.source_b_operand[`MDV_HALF-1:0]};
  assign b_high_in = {sgn & issue.source_b_operand[`MDV_W-1],
                      issue.source_b_operand[`MDV_W-1:`MDV_HALF]};

  // Second pass reuses the single multiplier with the saved operands
  assign mul_a = (s_q.st == st_pass2) ? s_q.mcand : a_ext;
  assign mul_b = (s_q.st == st_pass2) ? s_q.b_high : b_low;

  mdv_product_signed u_product_signed (
    .mcand(mul_a),
    .mplier(mul_b),
    .prod(prod)
  );

  mdv_early_in u_early (
    .dividend(issue.source_a_operand),
    .is_signed(sgn),
    .plan(plan)
  );

  assign prod64 = {{(2*`MDV_W-`MDV_PROD_W){prod[`MDV_PROD_W-1]}}, prod};
  assign a_mag = (sgn & issue.source_a_operand[`MDV_W-1]) ?
    (~issue.source_a_operand + 32'h1) : issue.source_a_operand;

  // Restoring step: one quotient bit
  assign div_rt = {s_q.rem, s_q.quo[`MDV_W-1]};

  always_comb begin
    s_d = s_q;
    full = prod64;
    base = {s_q.top, s_q.bot};
    rem_n = s_q.rem;
    quo_n = s_q.quo;
    // Register-target product leaves one stage after it is formed
    s_d.gpr = s_q.stage;
    s_d.stage = '0;

    case (s_q.st)
      st_pass2: begin
        // Second pass adds high-half product shifted by 16
        full = s_q.part + (prod64 << `MDV_HALF);
        s_d.st = st_idle;
      end
      st_divide: begin
        // Runs on its own; nothing from outside can hold it
        if (s_q.iter != '0) begin
          if (div_rt >= {1'h0, s_q.dvs}) begin
            rem_n = div_rt[`MDV_W-1:0] - s_q.dvs;
            quo_n = {s_q.quo[`MDV_W-2:0], 1'h1};
          end else begin
            rem_n = div_rt[`MDV_W-1:0];
            quo_n = {s_q.quo[`MDV_W-2:0], 1'h0};
          end
          s_d.iter = s_q.iter - 6'h1;
        end
        s_d.rem = rem_n;
        s_d.quo = quo_n;
        s_d.cyc = s_q.cyc - 6'h1;
        // Padding cycles after the bits keep the fixed latency
        if (s_q.cyc == 6'h1) begin
          s_d.bot = s_q.neg_quo ? (~quo_n + 32'h1) : quo_n;
          s_d.top = s_q.neg_rem ? (~rem_n + 32'h1) : rem_n;
          s_d.st = st_idle;
          // Forward so an op taken this cycle sees the divide result
          base = {s_d.top, s_d.bot};
        end
      end
      default: begin
        s_d.st = st_idle;
      end
    endcase

    // Finish a two-pass multiply
    if (s_q.st == st_pass2) begin
      case (s_q.op)
        op_product_accumulate_signed, op_product_accumulate_unsigned:
          {s_d.top, s_d.bot} = base + full;
        op_product_subtract_signed, op_product_subtract_unsigned:
          {s_d.top, s_d.bot} = base - full;
        op_product_to_register:
          s_d.stage = '{1'h1, full[`MDV_W-1:0]};
        default:
          {s_d.top, s_d.bot} = full;
      endcase
    end

    if (accept) begin
      s_d.op = issue.op;
      if (op_divide(issue.op)) begin
        // Early-in: start with the dividend already shifted up
        s_d.st = st_divide;
        s_d.quo = a_mag << plan.skip;
        s_d.iter = plan.iters;
        s_d.cyc = plan.reps;
        s_d.rem = '0;
        s_d.dvs = (sgn & issue.source_b_operand[`MDV_W-1]) ?
          (~issue.source_b_operand + 32'h1) : issue.source_b_operand;
        s_d.neg_quo = sgn & (issue.source_a_operand[`MDV_W-1] ^
                             issue.source_b_operand[`MDV_W-1]);
        s_d.neg_rem = sgn & issue.source_a_operand[`MDV_W-1];
      end else if (!fits16) begin
        // Keep first pass and operands for the second pass
        s_d.st = st_pass2;
        s_d.part = prod64;
        s_d.mcand = a_ext;
        s_d.b_high = b_high_in;
      end else begin
        s_d.st = st_idle;
        case (issue.op)
          op_product_accumulate_signed, op_product_accumulate_unsigned:
            {s_d.top, s_d.bot} = base + prod64;
          op_product_subtract_signed, op_product_subtract_unsigned:
            {s_d.top, s_d.bot} = base - prod64;
          op_product_to_register:
            s_d.stage = '{1'h1, prod64[`MDV_W-1:0]};
          default:
            {s_d.top, s_d.bot} = prod64;
        endcase
      end
    end

    // Busy through a second pass and all divide cycles but the last
    s_d.busy = (s_d.st == st_pass2) ||
      ((s_d.st == st_divide) && (s_d.cyc != 6'h1));
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{st: st_idle, op: op_product_signed, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign result_top_word = s_q.top;
  assign result_bottom_word = s_q.bot;
  assign gpr_result = s_q.gpr;

endmodule

// *** logic/mdv_pkg.sv ***
`include "mdv_cfg.svh"

package mdv_pkg;

  typedef enum logic [`MDV_OP_W-1:0] {
    op_product_signed = 4'h0,
    op_product_unsigned = 4'h1,
    op_product_accumulate_signed = 4'h2,
    op_product_accumulate_unsigned = 4'h3,
    op_product_subtract_signed = 4'h4,
    op_product_subtract_unsigned = 4'h5,
    op_product_to_register = 4'h6,
    op_quotient_signed = 4'h7,
    op_quotient_unsigned = 4'h8
  } mdv_op_e;

  typedef enum logic [2:0] {
    st_idle = 3'h1,
    st_pass2 = 3'h2,
    st_divide = 3'h4
  } mdv_state_e;

  typedef struct packed {
    logic valid;
    mdv_op_e op;
    logic [`MDV_W-1:0] source_a_operand;
    logic [`MDV_W-1:0] source_b_operand;
  } mdv_issue_s;

  typedef struct packed {
    logic valid;
    logic [`MDV_W-1:0] data;
  } mdv_gpr_s;

  typedef struct packed {
    logic [`MDV_CNT_W-1:0] skip;
    logic [`MDV_CNT_W-1:0] iters;
    logic [`MDV_CNT_W-1:0] reps;
  } mdv_div_plan_s;

endpackage

// *** logic/mdv_product_signed.sv ***
`timescale 1ns/1ps
`include "mdv_cfg.svh"

// One pass of the 32x16 multiplier; operands arrive already extended
module mdv_product_signed (
  input wire logic signed [`MDV_W:0] mcand,
  input wire logic signed [`MDV_HALF:0] mplier,
  output logic signed [`MDV_PROD_W-1:0] prod
);
  import mdv_pkg::*;

  localparam int PW = `MDV_PROD_W;

  // Widen both factors on purpose; size casts keep their sign
  assign prod = PW'(mcand) * PW'(mplier);

endmodule

// *** test/mdv_checker.sv ***
`timescale 1ns/1ps
module mdv_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input mdv_pkg::mdv_issue_s issue,
  input wire logic busy,
  input wire logic [31:0] result_top_word,
  input wire logic [31:0] result_bottom_word,
  input mdv_pkg::mdv_gpr_s gpr_result
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire [3:0] op = issue.op;
  wire [31:0] a = issue.source_a_operand;
  wire [31:0] b = issue.source_b_operand;
  wire tk = issue.valid && !busy;
  wire sg = (!op[0] && op != 4'h8) || op == 4'h7;
  wire fit = sg ? (&b[31:15] || ~|b[31:15]) : ~|b[31:16];
  wire pr = tk && op <= 4'h5;
  wire gp = tk && op == 4'h6;
  wire dv = tk && (op == 4'h7 || op == 4'h8);
  wire u8 = dv && op[3] && ~|a[31:8] && |b;
  wire [63:0] w = {result_top_word, result_bottom_word};
  wire signed [63:0] sp = $signed(a) * $signed(b);
  wire [31:0] sl = sp[31:0];
  wire [63:0] mac = w + sp;
  wire [63:0] uq = {a % b, a / b};
  div_busy_a: assert property (dv |=> busy [*8])
    else $error("busy dropped early in a divide");
  div_free_a: assert property (u8 |-> ##10 busy ##1 !busy)
    else $error("short divide repeat rate wrong");
  div_word_a: assert property (u8 |-> ##12
    ($past(issue.valid) || w == $past(uq, 12)))
    else $error("divide result wrong or late");
  pass_one_a: assert property (pr && fit |=> !busy)
    else $error("single pass multiply stalled issue");
  pass_two_a: assert property (pr && !fit |=> busy ##1 !busy)
    else $error("two pass multiply interlock wrong");
  mul_word_a: assert property (tk && op == 4'h0 && fit |=> w == $past(sp))
    else $error("product not in result words at latency 1");
  // A divide result forwarded in this cycle is not yet on the words
  mac_word_a: assert property (tk && op == 4'h2 && fit && !$past(busy)
    |=> w == $past(mac))
    else $error("accumulate result wrong");
  gpr_fast_a: assert property (gp && fit |-> ##2
    gpr_result.valid && gpr_result.data == $past(sl, 2))
    else $error("register product wrong or not at latency 2");
  gpr_slow_a: assert property (gp && !fit |-> ##3
    gpr_result.valid && gpr_result.data == $past(sl, 3))
    else $error("register product not at latency 3");
endmodule

bind mdv_muldiv_unit mdv_checker chk (.ref_clk, .rst_n, .issue, .busy,
  .result_top_word, .result_bottom_word, .gpr_result);

// *** test/mdv_int_pipe.sv ***
`timescale 1ns/1ps
module mdv_int_pipe (
  input wire logic ref_clk,
  input mdv_pkg::mdv_issue_s cmd,
  output mdv_pkg::mdv_issue_s issue
);
  logic [63:0] stale_q = 64'h0;
  // Operands flip outside an issue so a unit reading them late cannot pass
  always @(posedge ref_clk) begin
    stale_q <= cmd.valid ? ~{cmd.source_a_operand, cmd.source_b_operand}
                         : ~stale_q;
  end
  assign issue = cmd.valid ? cmd : {1'b0, cmd.op, stale_q};
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import mdv_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  mdv_issue_s cmd = '0;
  mdv_issue_s issue;
  mdv_gpr_s gpr_result;
  logic busy;
  logic [31:0] top_w;
  logic [31:0] bot_w;
  logic [63:0] acc = 64'h0;
  int fails = 0;
  int checks_done = 0;
  logic [31:0] gpr_seen = 32'h0;
  logic [31:0] gpr_exp = 32'h0;
  logic [31:0] sdv [4] = '{32'hFFFF_FF85, 32'hFFFF_8123, 32'hFF81_2345,
                           32'h8123_4567};
  logic [31:0] udv [4] = '{32'h0000_0085, 32'h0000_8123, 32'h0081_2345,
                           32'h8123_4567};
  logic [5:0] rep [4] = '{6'h0B, 6'h12, 6'h19, 6'h20};
  always #2.5 ref_clk = ~ref_clk;
  mdv_int_pipe ipipe (.ref_clk(ref_clk), .cmd(cmd), .issue(issue));
  mdv_muldiv_unit dut (.ref_clk(ref_clk), .rst_n(rst_n), .issue(issue),
    .busy(busy), .result_top_word(top_w), .result_bottom_word(bot_w),
    .gpr_result(gpr_result));

  // Last register-target product seen on its one-cycle pulse
  always @(posedge ref_clk) begin
    if (gpr_result.valid) begin
      gpr_seen <= gpr_result.data;
    end
  end

  function automatic logic [63:0] model(mdv_op_e op, logic [31:0] a,
                                        logic [31:0] b, logic [63:0] s);
    logic [63:0] sp;
    logic [63:0] up;
    sp = $signed(a) * $signed(b);
    up = {32'h0, a} * {32'h0, b};
    case (op)
      op_product_signed: model = sp;
      op_product_unsigned: model = up;
      op_product_accumulate_signed: model = s + sp;
      op_product_accumulate_unsigned: model = s + up;
      op_product_subtract_signed: model = s - sp;
      op_product_subtract_unsigned: model = s - up;
      op_quotient_signed: model = {$signed(a) % $signed(b),
                                   $signed(a) / $signed(b)};
      op_quotient_unsigned: model = {a % b, a / b};
      default: model = s;
    endcase
  endfunction

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(logic [63:0] exp, logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  // Request stays up unchanged until an edge sees busy low
  task automatic send(mdv_op_e op, logic [31:0] a, logic [31:0] b);
    int n;
    n = 0;
    cmd <= '{1'b1, op, a, b};
    acc = model(op, a, b, acc);
    if (op == op_product_to_register) begin
      gpr_exp = a * b;
    end
    @(posedge ref_clk);
    while (busy && n < 60) begin
      n++;
      @(posedge ref_clk);
    end
    if (n >= 60) begin
      fails++;
      report_and_stop();
    end
  endtask

  // Forty cycles covers the longest divide
  task automatic settle;
    cmd <= '0;
    repeat (40) @(posedge ref_clk);
    #1 check(acc, {top_w, bot_w});
    check(64'(gpr_exp), 64'(gpr_seen));
    @(posedge ref_clk);
  endtask

  task automatic div_time(mdv_op_e op, logic [31:0] a, logic [5:0] r);
    int n;
    send(op, a, 32'h0000_0003);
    cmd <= '0;
    n = 0;
    #1;
    while (busy && n < 60) begin
      n++;
      @(posedge ref_clk);
      #1;
    end
    check(64'(r - 6'h01), 64'(n));
    if (n >= 60) begin
      report_and_stop();
    end
    @(posedge ref_clk);
  endtask

  initial begin
    logic [31:0] a;
    logic [31:0] b;
    int sh;
    mdv_op_e op;
    void'($urandom(32'hACD3));
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      div_time(op_quotient_signed, sdv[i], rep[i]);
      settle();
      div_time(op_quotient_unsigned, udv[i], rep[i]);
      settle();
    end
    send(op_product_signed, 32'h8000_0001, 32'h7FFF_FFFF);
    send(op_product_unsigned, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    send(op_product_accumulate_unsigned, 32'hFFFF_FFFF, 32'h0000_FFFF);
    send(op_product_subtract_signed, 32'h1234_5678, 32'hFFFF_8000);
    send(op_product_to_register, 32'h0001_0001, 32'h0001_0000);
    send(op_product_accumulate_signed, 32'h8000_0000, 32'h0000_7FFF);
    settle();
    for (int t = 0; t < 80; t++) begin
      for (int k = 0; k < 4; k++) begin
        op = mdv_op_e'($urandom_range(0, 8));
        sh = 8 * $urandom_range(0, 3);
        a = $signed($urandom() << sh) >>> sh;
        sh = 16 * $urandom_range(0, 1);
        b = $signed($urandom() << sh) >>> sh;
        if (op >= op_quotient_signed) begin
          b = b | 32'h0000_0001;
        end
        send(op, a, b);
      end
      settle();
    end
    report_and_stop();
  end
endmodule
